// ==== rtl/bus_address_talk_only_ctrl.sv ====
// bus addressing, talk-only pacing and reading output path
// Notes on behaviour
// - addressed commands are ignored until our own listen address arrives.
// - readings go out only when addressed to talk, outside talk-only.
// - stored address defaults to 27 before any programming.
// - addresses 0 to 30 serve normal addressed operation.
// - new setting takes effect on menu exit and is written to storage.
// - setting 40 is talk-only with prefix, 41 talk-only without.
// - in talk-only every bus command is disregarded.
// - talker lamp lights while talk-only is active.
// - rate 0 sends one reading per 360 ms conversion.
// - rates 1 to 5 space readings 1 s, 10 s, 1 min, 10 min, 1 h.
// - rate 6 sends one reading per trigger button press.
// - talk-only sending starts after menu exit with no bus command.
// - listen address is the listen group byte built from our address.
`timescale 1ns/100ps

// ----------------------------------------------------------------
// byte fifo with registered ready towards the filler
// ----------------------------------------------------------------
module byte_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input  wire logic             sys_clk,   // clock
	input  wire logic             rst,       // async reset
	input  wire logic             in_valid,  // write request
	output logic                  in_ready,  // room for a word
	input  wire logic [WIDTH-1:0] in_data,   // write word
	output logic                  out_valid, // word available
	input  wire logic             out_ready, // drain accepts
	output logic      [WIDTH-1:0] out_data   // head word
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wp_reg, wp_next, rp_reg, rp_next;
	logic [AW:0]      cnt_reg, cnt_next;
	logic             rdy_reg, rdy_next;
	logic             push, pop;

	// pointer and count update
	always_comb begin
		push     = in_valid && rdy_reg;
		pop      = out_ready && (cnt_reg != '0);
		wp_next  = push ? wp_reg + 1'b1 : wp_reg;
		rp_next  = pop ? rp_reg + 1'b1 : rp_reg;
		cnt_next = cnt_reg + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
		rdy_next = (cnt_next != (AW+1)'(DEPTH));
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wp_reg  <= '0;
			rp_reg  <= '0;
			cnt_reg <= '0;
			rdy_reg <= 1'b1;
		end else begin
			wp_reg  <= wp_next;
			rp_reg  <= rp_next;
			cnt_reg <= cnt_next;
			rdy_reg <= rdy_next;
		end
	end

	// storage has no reset; only written words are ever read
	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem[wp_reg] <= in_data;
		end
	end

	assign in_ready  = rdy_reg;
	assign out_valid = (cnt_reg != '0);
	assign out_data  = mem[rp_reg];
endmodule : byte_fifo

// ----------------------------------------------------------------
// top
// ----------------------------------------------------------------
module bus_address_talk_only_ctrl
	import addr_ctrl_pkg::*;
#(
	parameter int CONV_CYC = CONV_CYCLES, // conversion period, cycles
	parameter int SEC_CYC  = SEC_CYCLES   // one second, cycles
) (
	input  wire logic       sys_clk,          // 40 MHz clock
	input  wire logic       rst,              // async reset, high
	input  wire logic [3:0] reg_addr,         // register byte address
	input  wire logic [31:0] reg_wdata,       // write data
	input  wire logic       reg_wr,           // write strobe
	input  wire logic       reg_rd,           // read strobe
	output logic     [31:0] reg_rdata,        // read data, next cycle
	input  wire logic [1:0] value_step_buttons, // [0] up, [1] down pin
	input  wire logic       menu_exit_button, // exit pin
	input  wire logic       manual_trigger_button, // trigger pin
	input  wire logic       nv_load,          // stored value valid pulse
	input  wire logic [5:0] nv_value,         // stored address
	output logic            nv_store,         // write storage pulse
	output logic      [5:0] nv_store_value,   // value to store
	input  wire logic       cmd_valid,        // received byte pulse
	input  wire bus_byte_t  cmd_in,           // received byte
	input  wire logic       ifc,              // interface clear pulse
	output logic            acc_valid,        // accepted byte pulse
	output bus_byte_t       acc_out,          // accepted byte
	output logic            listen_active,    // addressed to listen
	output logic            talk_active,      // addressed to talk
	output logic            talk_led,         // front talker lamp
	output logic            prefix_en,        // prefix on readings
	output logic            reading_req,      // request a reading
	input  wire logic       rd_valid,         // reading byte valid
	output logic            rd_ready,         // fifo has room
	input  wire logic [7:0] rd_data,          // reading byte
	output logic            tx_valid,         // byte to send
	input  wire logic       tx_ready,         // source handshake takes
	output logic      [7:0] tx_data           // byte on the bus
);
	// ----------------------------------------------------------------
	// pin synchronisers and press detection
	// ----------------------------------------------------------------
	logic [3:0] pin_raw, s1_reg, s2_reg, prev_reg, press;
	assign pin_raw = {manual_trigger_button, menu_exit_button,
		value_step_buttons};

	// first stage feeds only the second stage
	generate
		for (genvar i = 0; i < 4; i++) begin : g_sync
			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst) begin
					s1_reg[i]   <= 1'b0;
					s2_reg[i]   <= 1'b0;
					prev_reg[i] <= 1'b0;
				end else begin
					s1_reg[i]   <= pin_raw[i];
					s2_reg[i]   <= s1_reg[i];
					prev_reg[i] <= s2_reg[i];
				end
			end
			assign press[i] = s2_reg[i] && !prev_reg[i];
		end
	endgenerate

	// ----------------------------------------------------------------
	// address setting: menu value, active value, storage
	// ----------------------------------------------------------------
	logic [5:0] sel_reg, sel_next, act_reg, act_next;
	logic       nvs_reg, nvs_next;
	mode_t      mode_reg, mode_next;

	always_comb begin
		sel_next  = sel_reg;
		act_next  = act_reg;
		nvs_next  = 1'b0;
		mode_next = mode_reg;
		if (nv_load) begin
			sel_next = nv_value;
		end else if (press[0]) begin
			// skip 31..39 and stop at 41
			if (sel_reg < ADDR_MAX)
				sel_next = sel_reg + 6'h01;
			else if (sel_reg == ADDR_MAX)
				sel_next = ADDR_TALK_PFX;
			else
				sel_next = ADDR_TALK_RAW;
		end else if (press[1]) begin
			if (sel_reg == ADDR_TALK_RAW)
				sel_next = ADDR_TALK_PFX;
			else if (sel_reg == ADDR_TALK_PFX)
				sel_next = ADDR_MAX;
			else if (sel_reg != 6'h00)
				sel_next = sel_reg - 6'h01;
		end
		// exit commits the setting and stores it
		if (press[2]) begin
			act_next = sel_reg;
			nvs_next = 1'b1;
		end else if (nv_load) begin
			act_next = nv_value;
		end
		case (act_next)
			ADDR_TALK_PFX: mode_next = MODE_TALK_PFX;
			ADDR_TALK_RAW: mode_next = MODE_TALK_RAW;
			default:       mode_next = MODE_ADDRESSED;
		endcase
	end

	// factory value until storage reports
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			sel_reg  <= ADDR_DEFAULT;
			act_reg  <= ADDR_DEFAULT;
			nvs_reg  <= 1'b0;
			mode_reg <= MODE_ADDRESSED;
		end else begin
			sel_reg  <= sel_next;
			act_reg  <= act_next;
			nvs_reg  <= nvs_next;
			mode_reg <= mode_next;
		end
	end

	// ----------------------------------------------------------------
	// listener and talker addressing
	// ----------------------------------------------------------------
	logic      lis_reg, lis_next, tlk_reg, tlk_next;
	logic      accv_reg, accv_next;
	bus_byte_t acc_reg, acc_next;
	logic      tonly, is_mla, is_mta, is_tag;

	always_comb begin
		tonly  = (mode_reg != MODE_ADDRESSED);
		// own listen and talk bytes
		is_mla = cmd_in.data[6:5] == GRP_LISTEN &&
			cmd_in.data[4:0] == act_reg[4:0];
		is_mta = cmd_in.data[6:5] == GRP_TALK &&
			cmd_in.data[4:0] == act_reg[4:0];
		is_tag = cmd_in.data[6:5] == GRP_TALK;
		lis_next  = lis_reg;
		tlk_next  = tlk_reg;
		accv_next = 1'b0;
		acc_next  = cmd_in;
		if (tonly || ifc) begin
			// bus is not listened to at all
			lis_next = 1'b0;
			tlk_next = 1'b0;
		end else if (cmd_valid && cmd_in.atn) begin
			if (is_mla) begin
				lis_next = 1'b1;
				tlk_next = 1'b0;
			end else if (cmd_in.data[6:0] == CMD_UNL) begin
				lis_next = 1'b0;
			end else if (is_mta) begin
				tlk_next = 1'b1;
				lis_next = 1'b0;
			end else if (is_tag) begin
				tlk_next = 1'b0; // other talker or untalk
			end else if (cmd_in.data[6:4] != GRP_ACG || lis_reg) begin
				// addressed group only while listening
				accv_next = 1'b1;
			end
		end else if (cmd_valid && lis_reg) begin
			accv_next = 1'b1; // device data needs listener
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			lis_reg  <= 1'b0;
			tlk_reg  <= 1'b0;
			accv_reg <= 1'b0;
			acc_reg  <= '0;
		end else begin
			lis_reg  <= lis_next;
			tlk_reg  <= tlk_next;
			accv_reg <= accv_next;
			acc_reg  <= acc_next;
		end
	end

	// ----------------------------------------------------------------
	// talk-only pacing
	// ----------------------------------------------------------------
	logic [2:0]  rate_reg, rate_next;
	logic [23:0] conv_reg, conv_next;
	logic [25:0] sec_reg, sec_next;
	logic [11:0] secs_reg, secs_next, secs_lim;
	logic        req_reg, req_next, conv_tick, sec_tick;

	always_comb begin
		rate_next = rate_reg;
		if (reg_wr && reg_addr == REG_RATE)
			rate_next = reg_wdata[2:0];
		case (rate_reg)
			3'h1:    secs_lim = SECS_R1;
			3'h2:    secs_lim = SECS_R2;
			3'h3:    secs_lim = SECS_R3;
			3'h4:    secs_lim = SECS_R4;
			default: secs_lim = SECS_R5;
		endcase
		// exit restarts every pacing counter; a rate change restarts only the second counters
		conv_tick = conv_reg == 24'(CONV_CYC - 1);
		sec_tick  = sec_reg == 26'(SEC_CYC - 1);
		conv_next = (conv_tick || press[2]) ? '0 : conv_reg + 24'h1;
		sec_next  = (sec_tick || press[2] || rate_next != rate_reg) ? '0 :
			sec_reg + 26'h1;
		secs_next = secs_reg;
		if (press[2] || rate_next != rate_reg)
			secs_next = '0;
		else if (sec_tick)
			secs_next = (secs_reg == secs_lim - 12'h1) ? '0 :
				secs_reg + 12'h1;
		req_next = 1'b0;
		if (tonly && !press[2]) begin
			case (rate_reg)
				3'h0: req_next = conv_tick;
				3'h1, 3'h2, 3'h3, 3'h4, 3'h5:
					req_next = sec_tick &&
						secs_reg == secs_lim - 12'h1;
				RATE_MANUAL_TRIGGER_BUTTON: req_next = press[3];
				default: req_next = 1'b0;
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rate_reg <= RATE_RESET;
			conv_reg <= '0;
			sec_reg  <= '0;
			secs_reg <= '0;
			req_reg  <= 1'b0;
		end else begin
			rate_reg <= rate_next;
			conv_reg <= conv_next;
			sec_reg  <= sec_next;
			secs_reg <= secs_next;
			req_reg  <= req_next;
		end
	end

	// ----------------------------------------------------------------
	// reading path: fifo then registered output stage
	// ----------------------------------------------------------------
	logic       f_valid, f_pop, txv_reg, txv_next, send_ok;
	logic [7:0] f_data, txd_reg, txd_next;

	byte_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.in_valid (rd_valid),
		.in_ready (rd_ready),
		.in_data  (rd_data),
		.out_valid(f_valid),
		.out_ready(f_pop),
		.out_data (f_data)
	);

	// bytes wait in the fifo until sending is allowed
	always_comb begin
		send_ok  = tlk_reg || tonly;
		f_pop    = send_ok && f_valid && (!txv_reg || tx_ready);
		txv_next = txv_reg;
		txd_next = txd_reg;
		if (f_pop) begin
			txv_next = 1'b1;
			txd_next = f_data;
		end else if (tx_ready) begin
			txv_next = 1'b0;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			txv_reg <= 1'b0;
			txd_reg <= '0;
		end else begin
			txv_reg <= txv_next;
			txd_reg <= txd_next;
		end
	end

	// ----------------------------------------------------------------
	// register read port
	// ----------------------------------------------------------------
	logic [31:0] rdat_reg, rdat_next;
	logic        led_reg, pfx_reg;

	always_comb begin
		rdat_next = '0;
		if (reg_rd) begin
			case (reg_addr)
				REG_STATUS: begin
					rdat_next[5:0]     = act_reg;
					rdat_next[ST_LISTEN] = lis_reg;
					rdat_next[ST_TALK]   = tlk_reg;
					rdat_next[ST_TONLY]  = tonly;
				end
				REG_RATE: rdat_next[2:0] = rate_reg;
				REG_MENU: rdat_next[5:0] = sel_reg;
				default:  rdat_next = '0;
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rdat_reg <= '0;
			led_reg  <= 1'b0;
			pfx_reg  <= 1'b0;
		end else begin
			rdat_reg <= rdat_next;
			led_reg  <= tonly;
			pfx_reg  <= (mode_reg == MODE_TALK_PFX);
		end
	end

	assign reg_rdata      = rdat_reg;
	assign nv_store       = nvs_reg;
	assign nv_store_value = act_reg;
	assign acc_valid      = accv_reg;
	assign acc_out        = acc_reg;
	assign listen_active  = lis_reg;
	assign talk_active    = tlk_reg;
	assign talk_led       = led_reg;
	assign prefix_en      = pfx_reg;
	assign reading_req    = req_reg;
	assign tx_valid       = txv_reg;
	assign tx_data        = txd_reg;
endmodule : bus_address_talk_only_ctrl

// ==== rtl/addr_ctrl_pkg.sv ====
// constants and types shared by the bus addressing and talk-only block
package addr_ctrl_pkg;
	// ----------------------------------------------------------------
	// address settings
	// ----------------------------------------------------------------
	localparam logic [5:0] ADDR_DEFAULT  = 6'h1B; // 27
	localparam logic [5:0] ADDR_MAX      = 6'h1E; // 30
	localparam logic [5:0] ADDR_TALK_PFX = 6'h28; // 40
	localparam logic [5:0] ADDR_TALK_RAW = 6'h29; // 41
	// ----------------------------------------------------------------
	// command bytes (seven bit, parity bit ignored)
	// ----------------------------------------------------------------
	localparam logic [1:0] GRP_LISTEN = 2'h1;
	localparam logic [1:0] GRP_TALK   = 2'h2;
	localparam logic [6:0] CMD_UNL    = 7'h3F;
	localparam logic [6:0] CMD_UNT    = 7'h5F;
	localparam logic [2:0] GRP_ACG    = 3'h0;  // 0x00..0x0F
	// ----------------------------------------------------------------
	// register map and field positions
	// ----------------------------------------------------------------
	localparam logic [3:0] REG_STATUS = 4'h0;
	localparam logic [3:0] REG_RATE   = 4'h4;
	localparam logic [3:0] REG_MENU   = 4'h8;
	localparam int         ST_LISTEN  = 6;
	localparam int         ST_TALK    = 7;
	localparam int         ST_TONLY   = 8;
	localparam logic [2:0] RATE_RESET = 3'h0;
	localparam logic [2:0] RATE_MANUAL_TRIGGER_BUTTON  = 3'h6;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ      = 40000000;
	localparam int CONV_MS     = 360;
	localparam int CONV_CYCLES = CLK_HZ / 1000 * CONV_MS;
	localparam int SEC_CYCLES  = CLK_HZ;
	localparam logic [11:0] SECS_R1 = 12'h001; // 1 s
	localparam logic [11:0] SECS_R2 = 12'h00A; // 10 s
	localparam logic [11:0] SECS_R3 = 12'h03C; // 1 min
	localparam logic [11:0] SECS_R4 = 12'h258; // 10 min
	localparam logic [11:0] SECS_R5 = 12'hE10; // 1 h
	localparam int FIFO_DEPTH = 32;
	localparam int FIFO_WIDTH = 8;
	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_ADDRESSED,
		MODE_TALK_PFX,
		MODE_TALK_RAW
	} mode_t;
	typedef struct packed {
		logic       atn;  // command (high) or data byte
		logic [7:0] data;
	} bus_byte_t;
endpackage : addr_ctrl_pkg

// ==== test/bus_listener_model.sv ====
// listen-only printer model on the far side of the reading output
`timescale 1ns/100ps
module bus_listener_model (
	input  wire logic sys_clk,  // clock
	input  wire logic rst,      // async reset, high
	input  wire logic slow,     // stall at random when high
	input  wire logic tx_valid, // byte offered by the source
	output logic      tx_ready  // byte taken on this edge
);
	// a printer owns no bus address, so it never clashes
	// a slow printer refuses about half the edges to stress the hold
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tx_ready <= 1'b0;
		end else begin
			tx_ready <= slow ? 1'($urandom_range(1)) : 1'b1;
		end
	end
endmodule : bus_listener_model

// ==== test/addr_ctrl_assertions.sv ====
// checker for the bus addressing and talk-only block
`timescale 1ns/100ps
module addr_ctrl_checker
	import addr_ctrl_pkg::*;
#(
	parameter int CONV_CYC = CONV_CYCLES, // conversion period
	parameter int SEC_CYC  = SEC_CYCLES   // one second
) (
	input wire logic       sys_clk,        // clock
	input wire logic       rst,            // async reset
	input wire logic       cmd_valid,      // received byte pulse
	input wire bus_byte_t  cmd_in,         // received byte
	input wire logic       acc_valid,      // accepted byte pulse
	input wire logic       listen_active,  // addressed to listen
	input wire logic       talk_active,    // addressed to talk
	input wire logic       talk_led,       // talk-only lamp
	input wire logic       prefix_en,      // prefix on readings
	input wire logic       reading_req,    // reading due
	input wire logic       nv_store,       // storage write pulse
	input wire logic [5:0] nv_store_value, // active address
	input wire logic       tx_valid,       // byte offered
	input wire logic       tx_ready        // byte taken
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// ------
	// listen byte built from the active address
	// ------
	logic [6:0] own_lag; // our listen group byte
	assign own_lag = {GRP_LISTEN, nv_store_value[4:0]};
	property p_own_listen;
		cmd_valid && cmd_in.atn && cmd_in.data[6:0] == own_lag && !talk_led
			&& nv_store_value <= ADDR_MAX |=> listen_active;
	endproperty
	a_own_listen: assert property (p_own_listen)
		else $error("own listen byte ignored");
	property p_acg_deaf;
		cmd_valid && cmd_in.atn && cmd_in.data[6:4] == GRP_ACG
			&& !listen_active |=> !acc_valid;
	endproperty
	a_acg_deaf: assert property (p_acg_deaf)
		else $error("addressed command taken while not listening");
	property p_data_deaf;
		cmd_valid && !cmd_in.atn && !listen_active |=> !acc_valid;
	endproperty
	a_data_deaf: assert property (p_data_deaf)
		else $error("data byte taken while not listening");
	property p_talk_first;
		$rose(tx_valid) |-> $past(talk_active) || talk_led;
	endproperty
	a_talk_first: assert property (p_talk_first)
		else $error("byte offered without talker state");
	property p_tonly_deaf;
		cmd_valid && (nv_store_value == ADDR_TALK_PFX ||
			nv_store_value == ADDR_TALK_RAW) |=> !acc_valid &&
			!listen_active && !talk_active;
	endproperty
	a_tonly_deaf: assert property (p_tonly_deaf)
		else $error("command obeyed in talk-only");
	property p_prefix;
		prefix_en |-> talk_led;
	endproperty
	a_prefix: assert property (p_prefix)
		else $error("prefix outside talk-only");
	property p_req_tonly;
		reading_req |-> talk_led;
	endproperty
	a_req_tonly: assert property (p_req_tonly)
		else $error("reading requested outside talk-only");
	property p_req_gap;
		reading_req |=> !reading_req [*5];
	endproperty
	a_req_gap: assert property (p_req_gap)
		else $error("reading requests too close");
	property p_store;
		nv_store |-> (nv_store_value <= ADDR_MAX || nv_store_value ==
			ADDR_TALK_PFX || nv_store_value == ADDR_TALK_RAW) ##1 !nv_store;
	endproperty
	a_store: assert property (p_store)
		else $error("bad stored setting or long pulse");
	property p_default;
		$fell(rst) |-> nv_store_value == ADDR_DEFAULT;
	endproperty
	a_default: assert property (p_default)
		else $error("address not default after reset");
	c_listen: cover property ($rose(listen_active));
	c_req: cover property (reading_req);
	c_tx: cover property (tx_valid && tx_ready);
	c_store: cover property (nv_store && talk_led);
endmodule : addr_ctrl_checker

bind bus_address_talk_only_ctrl addr_ctrl_checker #(
	.CONV_CYC(CONV_CYC),
	.SEC_CYC(SEC_CYC)
) u_addr_ctrl_checker (.sys_clk, .rst, .cmd_valid, .cmd_in, .acc_valid,
	.listen_active, .talk_active, .talk_led, .prefix_en, .reading_req,
	.nv_store, .nv_store_value, .tx_valid, .tx_ready);

// ==== test/tb_bus_address_talk_only_ctrl.sv ====
// self-checking bench for the bus addressing and talk-only block
`timescale 1ns/100ps
module tb_bus_address_talk_only_ctrl;
	import addr_ctrl_pkg::*;
	localparam int CONV = 20; // shortened conversion period
	localparam int SEC  = 10; // shortened second
	logic        sys_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, ifc = 0;
	logic [3:0]  reg_addr = 0, btn = 0;
	logic [31:0] reg_wdata = 0, reg_rdata, v;
	logic        nv_load = 0, nv_store, cmd_valid = 0, acc_valid, slow = 1;
	logic [5:0]  nv_value = 0, nv_store_value, a, m, st_val;
	bus_byte_t   cmd_in = '0, acc_out;
	logic        listen_active, talk_active, talk_led, prefix_en;
	logic        reading_req, rd_valid = 0, rd_ready, tx_valid, tx_ready;
	logic [7:0]  rd_data = 0, tx_data;
	logic [7:0]  exp_q[$], got_q[$];
	int          n_errors = 0, n_compared = 0, n_acc = 0, n_req = 0, c, r;
	always #12.5 sys_clk = ~sys_clk;
	bus_address_talk_only_ctrl #(.CONV_CYC(CONV), .SEC_CYC(SEC))
	u_bus_address_talk_only_ctrl (.sys_clk, .rst, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .value_step_buttons(btn[1:0]),
		.menu_exit_button(btn[2]), .manual_trigger_button(btn[3]), .nv_load,
		.nv_value, .nv_store, .nv_store_value, .cmd_valid, .cmd_in, .ifc,
		.acc_valid, .acc_out, .listen_active, .talk_active, .talk_led,
		.prefix_en, .reading_req, .rd_valid, .rd_ready, .rd_data, .tx_valid,
		.tx_ready, .tx_data);
	bus_listener_model u_bus_listener_model (.sys_clk, .rst, .slow,
		.tx_valid, .tx_ready);
	// ------
	// monitor: records handshakes, renews fill data once it is taken
	// ------
	always @(posedge sys_clk) begin
		if (rd_valid && rd_ready) begin
			exp_q.push_back(rd_data);
			rd_data <= 8'($urandom);
		end
		if (tx_valid && tx_ready) got_q.push_back(tx_data);
		if (acc_valid && acc_out.data[6:0] inside {7'h04, 7'h46}) n_acc++;
		if (reading_req) n_req++;
		if (nv_store) st_val = nv_store_value;
	end
	function automatic logic [7:0] addr_byte(logic [2:0] g, logic [5:0] x);
		return {g, x[4:0]};
	endfunction : addr_byte
	// menu stepping skips 31..39 and saturates at both ends
	function automatic logic [5:0] step(logic [5:0] x, logic up);
		if (up) return x == ADDR_MAX ? ADDR_TALK_PFX :
			x == ADDR_TALK_RAW ? x : x + 6'h01;
		return x == ADDR_TALK_PFX ? ADDR_MAX : x == 6'h00 ? x : x - 6'h01;
	endfunction : step
	function automatic int period(int k);
		int s[6] = '{0, 1, 10, 60, 600, 3600};
		return k == 0 ? CONV : s[k] * SEC;
	endfunction : period
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// one register access; read data lands in v
	task automatic bus(logic w, logic [3:0] ad, logic [31:0] d);
		@(posedge sys_clk);
		reg_wr <= w;
		reg_rd <= !w;
		reg_addr <= ad;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask : bus
	task automatic cmd(logic atn, logic [7:0] b);
		@(posedge sys_clk);
		cmd_valid <= 1'b1;
		cmd_in <= '{atn, b};
		@(posedge sys_clk);
		cmd_valid <= 1'b0;
	endtask : cmd
	// pins pass a two-stage sync, so hold for four edges
	task automatic press(int k);
		@(posedge sys_clk);
		btn[k] <= 1'b1;
		repeat (4) @(posedge sys_clk);
		btn[k] <= 1'b0;
		repeat (4) @(posedge sys_clk);
	endtask : press
	task automatic walk(logic [5:0] t, logic up);
		for (int g = 0; g < 45 && m != t; g++) begin
			press(up ? 0 : 1);
			m = step(m, up);
			bus(0, REG_MENU, 0);
			chk("menu", 32'(m), v);
		end
	endtask : walk
	task automatic commit(logic led, logic pfx);
		st_val = 6'h3F;
		press(2);
		chk("stored", 32'(m), 32'(st_val));
		chk("lamp", 32'(led), 32'(talk_led));
		chk("prefix", 32'(pfx), 32'(prefix_en));
	endtask : commit
	task automatic stream(int n);
		@(posedge sys_clk);
		rd_valid <= 1'b1;
		repeat (n) @(posedge sys_clk);
		rd_valid <= 1'b0;
	endtask : stream
	task automatic same();
		chk("count", 32'(exp_q.size()), 32'(got_q.size()));
		foreach (got_q[i]) chk("order", 32'(exp_q[i]), 32'(got_q[i]));
	endtask : same
	task automatic wait_req(int lim);
		c = 0;
		do begin
			@(posedge sys_clk);
			#1 c++;
		end while (!reading_req && c < lim);
	endtask : wait_req
	task automatic stop_test();
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : stop_test
	// ------
	// main sequence
	// ------
	initial begin
		c = $urandom(86);
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		bus(1, REG_STATUS, 32'hFFFFFFFF);
		bus(0, REG_STATUS, 0);
		chk("status", 32'(ADDR_DEFAULT), v);
		bus(0, REG_RATE, 0);
		chk("rate", 32'(RATE_RESET), v);
		bus(0, 4'hC, 0);
		chk("unmapped", 0, v);
		// random stored address, then only our own listen byte counts
		a = 6'($urandom_range(30));
		@(posedge sys_clk);
		nv_load <= 1'b1;
		nv_value <= a;
		@(posedge sys_clk);
		nv_load <= 1'b0;
		bus(0, REG_STATUS, 0);
		chk("loaded", 32'(a), v);
		cmd(1, 8'h04);
		cmd(0, 8'h46);
		cmd(1, addr_byte(3'h1, (a + 6'h01) % 6'h1F));
		cmd(1, 8'h04);
		cmd(1, addr_byte(3'h1, a));
		cmd(1, 8'h04);
		cmd(0, 8'h46);
		repeat (2) @(posedge sys_clk);
		chk("accepted", 2, n_acc);
		bus(0, REG_STATUS, 0);
		chk("listener", 32'(a) | (32'h1 << ST_LISTEN), v);
		cmd(1, {1'b0, CMD_UNL});
		bus(0, REG_STATUS, 0);
		chk("unlisten", 32'(a), v);
		// an idle device buffers readings until the fifo refuses
		stream(40);
		#1 chk("silent", 0, 32'(got_q.size()));
		chk("full", 0, 32'(rd_ready));
		chk("filled", 32, 32'(exp_q.size()));
		cmd(1, addr_byte(3'h2, a));
		for (c = 0; c < 400 && got_q.size() < 32; c++) @(posedge sys_clk);
		same();
		cmd(1, {1'b0, CMD_UNT});
		bus(0, REG_STATUS, 0);
		chk("untalk", 32'(a), v);
		cmd(1, addr_byte(3'h1, a));
		@(posedge sys_clk);
		ifc <= 1'b1;
		@(posedge sys_clk);
		ifc <= 1'b0;
		bus(0, REG_STATUS, 0);
		chk("cleared", 32'(a), v);
		// talk-only with prefix ignores the bus and sends unasked
		bus(0, REG_MENU, 0);
		m = v[5:0];
		walk(ADDR_TALK_PFX, 1);
		commit(1, 1);
		cmd(1, addr_byte(3'h1, a));
		cmd(1, addr_byte(3'h2, a));
		bus(0, REG_STATUS, 0);
		chk("deaf", 32'(ADDR_TALK_PFX) | (32'h1 << ST_TONLY), v);
		exp_q.delete();
		got_q.delete();
		stream(6);
		repeat (60) @(posedge sys_clk);
		same();
		for (r = 0; r < 6; r++) begin
			bus(1, REG_RATE, 32'(r));
			wait_req(40000);
			if (r == 5) begin
				chk("hour", 1, 32'(c > period(5) - 4 && c < period(5) + 4));
			end else begin
				wait_req(40000);
				chk("period", 32'(period(r)), 32'(c));
			end
		end
		bus(1, REG_RATE, 32'(RATE_MANUAL_TRIGGER_BUTTON));
		bus(0, REG_RATE, 0);
		chk("rate rw", 32'(RATE_MANUAL_TRIGGER_BUTTON), v);
		c = n_req;
		press(3);
		press(3);
		repeat (30) @(posedge sys_clk);
		chk("triggered", 32'(c + 2), 32'(n_req));
		walk(ADDR_TALK_RAW, 1);
		press(0);
		bus(0, REG_MENU, 0);
		chk("menu top", 32'(ADDR_TALK_RAW), v);
		commit(1, 0);
		walk(ADDR_MAX, 0);
		commit(0, 0);
		stop_test();
	end
	// hang guard, well beyond the longest expected run
	initial begin
		#2000000;
		n_errors++;
		stop_test();
	end
endmodule : tb_bus_address_talk_only_ctrl
